// ### verilog/dtu_pkg.sv
// shared constants and types for the dual timer capture/reload unit
package dtu_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADR_W  = 8;
  localparam int DAT_W  = 32;
  localparam int SEL_W  = DAT_W / 8;
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 9;
  localparam int IRQ_W  = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_AUX_CTRL  = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CORE_CTRL = 8'h04;
  localparam logic [ADR_W-1:0] OFS_CAP_CTRL  = 8'h08;
  localparam logic [ADR_W-1:0] OFS_AUX_CNT   = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_CORE_CNT  = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CAPTURE_RELOAD_REG    = 8'h14;
  localparam logic [ADR_W-1:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [ADR_W-1:0] OFS_IRQ_CLR   = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_IRQ_EN    = 8'h20;

  // status bit positions
  localparam int IRQ_AUX_WRAP  = 0;
  localparam int IRQ_CORE_WRAP = 1;
  localparam int IRQ_CAPTURE   = 2;

  // synchronised pin positions
  localparam int PIN_N    = 7;
  localparam int P_CAP    = 0;
  localparam int P_AUX_IN = 1;
  localparam int P_COR_IN = 2;
  localparam int P_AUX_DR = 3;
  localparam int P_COR_DR = 4;
  localparam int P_OTH_CN = 5;
  localparam int P_OTH_DR = 6;

  // prescaler base: code 0 divides by four
  localparam logic [PRE_W:0] PRE_BASE = 10'h004;
  localparam logic [PRE_W:0] PRE_ONE  = 10'h001;

  // count limits and reset values
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // enumerations and field layouts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TIMER   = 2'b00,
    MODE_GATED   = 2'b01,
    MODE_COUNTER = 2'b10,
    MODE_LATCH   = 2'b11
  } dtu_mode_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } dtu_edge_t;

  typedef enum logic [1:0] {
    CSRC_PIN   = 2'b00,
    CSRC_OCNT  = 2'b01,
    CSRC_ODIR  = 2'b10,
    CSRC_OBOTH = 2'b11
  } dtu_csrc_t;

  // timer control word, bit 0 upward: sel, mode, gate_high, edge, down, ext_dir, run, ...
  typedef struct packed {
    logic      out_en;
    logic      reload_en;
    logic      run;
    logic      ext_dir_en;
    logic      dir_down;
    dtu_edge_t edge_sel;
    logic      gate_high;
    dtu_mode_t mode;
    logic [2:0] in_sel;
  } dtu_ctrl_t;

  typedef struct packed {
    dtu_csrc_t src;
    logic      clear_en;
    dtu_edge_t edge_sel;
  } dtu_capctl_t;

  localparam dtu_ctrl_t   CTRL_RST = '0;
  localparam dtu_capctl_t CAP_RST  = '0;

endpackage

// ### verilog/dtu_timer_unit.sv
// auxiliary and core timers with shared capture/reload register, wishbone slave
`timescale 1ns/1ps

// Notes on behaviour
// - The unit holds an auxiliary timer, a core timer and one shared capture/reload register.
// - Both timers are sixteen-bit counters.
// - Each timer counts the prescaled system clock or events on its input pin; the auxiliary timer can also count toggle latch flips.
// - The three-bit input select picks a divide factor of four doubling per code up to 512.
// - Plain timer and gated timer modes share the same prescaler selection and factors.
// - In gated mode a timer counts prescaled ticks only while its gate pin is at the active level.
// - In counter mode a timer advances on selected edges of its input pin.
// - Direction is set by software and may be inverted by a level on the timer's direction pin.
// - The core toggle latch inverts on every overflow and every underflow of the core timer.
// - The toggle latch can clock the auxiliary timer and can be driven onto an output pin.
// - Each core overflow or underflow is presented as a clock event for the compare timers.
// - When enabled, a core wrap reloads the core timer from the capture/reload register.
// - A selected edge on the capture pin copies the auxiliary count into capture/reload.
// - With clear-after-capture enabled the auxiliary timer goes to zero on each capture.
// - Capture may instead trigger on edges of the other module's count input, direction input or both.
module dtu_timer_unit (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [dtu_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [dtu_pkg::SEL_W-1:0] wb_sel_i,
  input  wire logic [dtu_pkg::DAT_W-1:0] wb_dat_i,
  output wire logic [dtu_pkg::DAT_W-1:0] wb_dat_o,
  output wire logic                      wb_ack_o,
  input  wire logic                      aux_in_pin,
  input  wire logic                      core_in_pin,
  input  wire logic                      aux_dir_pin,
  input  wire logic                      core_dir_pin,
  input  wire logic                      capture_in_pin,
  input  wire logic                      other_module_count_in,
  input  wire logic                      other_module_dir_in,
  output wire logic                      toggle_out_pin,
  output wire logic                      core_wrap_evt,
  output wire logic                      irq
);
  import dtu_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PRE_W-1:0] pres;
    dtu_ctrl_t        aux_c;
    dtu_ctrl_t        core_c;
    dtu_capctl_t      cap_c;
    logic [CNT_W-1:0] aux_cnt;
    logic [CNT_W-1:0] core_cnt;
    logic [CNT_W-1:0] capture_reload_reg;
    logic             latch;
    logic             wrap_evt;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] ien;
    logic             ack;
    logic [DAT_W-1:0] rdat;
  } dtu_state_t;

  dtu_state_t st;
  dtu_state_t next_st;

  // helper terms, also watched by the checks below
  logic             core_step;
  logic             aux_step;
  logic             core_wrap;
  logic             cap_trig;
  logic             wr_hit;
  logic [DAT_W-1:0] rmux;
  logic [DAT_W-1:0] wm;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // prescaler tick: low bits of the free counter all ones
  function automatic logic pres_tick(input logic [2:0] sel, input logic [PRE_W-1:0] pres);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'((PRE_BASE << sel) - PRE_ONE);
    return (pres & mask) == mask;
  endfunction

  // edge filter on synchronised samples
  function automatic logic edge_hit(input dtu_edge_t es, input logic rise, input logic fall);
    return (es[0] & rise) | (es[1] & fall);
  endfunction

  // count enable for one timer in its current mode
  function automatic logic step_en(input dtu_ctrl_t c, input logic tick, input logic lvl,
                                   input logic rise, input logic fall, input logic ltog);
    logic en;
    en = 1'b0;
    case (c.mode)
      MODE_TIMER:   en = tick;
      MODE_GATED:   en = tick & (lvl == c.gate_high);
      MODE_COUNTER: en = edge_hit(c.edge_sel, rise, fall);
      MODE_LATCH:   en = ltog;
      default:      en = 1'b0;
    endcase
    return c.run & en;
  endfunction

  // byte-lane merge of write data over the current value
  function automatic logic [DAT_W-1:0] wmerge(input logic [DAT_W-1:0] old,
                                              input logic [SEL_W-1:0] sel,
                                              input logic [DAT_W-1:0] dat);
    logic [DAT_W-1:0] r;
    r = old;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    case ({wb_adr_i[ADR_W-1:2], 2'b00})
      OFS_AUX_CTRL:  rmux = DAT_W'(st.aux_c);
      OFS_CORE_CTRL: rmux = DAT_W'(st.core_c);
      OFS_CAP_CTRL:  rmux = DAT_W'(st.cap_c);
      OFS_AUX_CNT:   rmux = DAT_W'(st.aux_cnt);
      OFS_CORE_CNT:  rmux = DAT_W'(st.core_cnt);
      OFS_CAPTURE_RELOAD_REG:    rmux = DAT_W'(st.capture_reload_reg);
      OFS_IRQ_STAT:  rmux = DAT_W'(st.ists);
      OFS_IRQ_EN:    rmux = DAT_W'(st.ien);
      default:       rmux = '0; // clear register and holes read zero
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [PIN_N-1:0] rise;
    logic [PIN_N-1:0] fall;
    logic             aux_down;
    logic             core_down;
    logic             aux_wrap;
    logic [IRQ_W-1:0] iclr;
    rise      = '0;
    fall      = '0;
    aux_step  = 1'b0;
    aux_down  = 1'b0;
    core_down = 1'b0;
    aux_wrap  = 1'b0;
    iclr      = '0;
    next_st   = st;

    next_st.s1 = {other_module_dir_in, other_module_count_in, core_dir_pin, aux_dir_pin,
                  core_in_pin, aux_in_pin, capture_in_pin};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    rise = st.s2 & ~st.s3;
    fall = ~st.s2 & st.s3;

    next_st.pres = st.pres + PRE_W'(1);

    // software direction, optionally flipped by pin
    core_down = st.core_c.dir_down ^ (st.core_c.ext_dir_en & st.s2[P_COR_DR]);
    aux_down  = st.aux_c.dir_down ^ (st.aux_c.ext_dir_en & st.s2[P_AUX_DR]);

    core_step = step_en(st.core_c, pres_tick(st.core_c.in_sel, st.pres), st.s2[P_COR_IN],
                        rise[P_COR_IN], fall[P_COR_IN], 1'b0);
    core_wrap = core_step & (core_down ? (st.core_cnt == CNT_ZERO)
                                       : (st.core_cnt == CNT_MAX));

    if (core_step) begin
      next_st.core_cnt = core_down ? st.core_cnt - CNT_W'(1) : st.core_cnt + CNT_W'(1);
    end
    if (core_wrap && st.core_c.reload_en) begin
      next_st.core_cnt = st.capture_reload_reg;
    end
    next_st.latch    = st.latch ^ core_wrap;
    next_st.wrap_evt = core_wrap;

    // aux may be clocked by latch toggles
    aux_step = step_en(st.aux_c, pres_tick(st.aux_c.in_sel, st.pres), st.s2[P_AUX_IN],
                       rise[P_AUX_IN], fall[P_AUX_IN], core_wrap);
    aux_wrap = aux_step & (aux_down ? (st.aux_cnt == CNT_ZERO)
                                    : (st.aux_cnt == CNT_MAX));
    if (aux_step) begin
      next_st.aux_cnt = aux_down ? st.aux_cnt - CNT_W'(1) : st.aux_cnt + CNT_W'(1);
    end

    case (st.cap_c.src)
      CSRC_PIN:   cap_trig = edge_hit(st.cap_c.edge_sel, rise[P_CAP], fall[P_CAP]);
      CSRC_OCNT:  cap_trig = rise[P_OTH_CN] | fall[P_OTH_CN];
      CSRC_ODIR:  cap_trig = rise[P_OTH_DR] | fall[P_OTH_DR];
      CSRC_OBOTH: cap_trig = rise[P_OTH_CN] | fall[P_OTH_CN] | rise[P_OTH_DR] | fall[P_OTH_DR];
      default:    cap_trig = 1'b0;
    endcase

    // bus handshake: ack one cycle after request, read data with it
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      next_st.rdat = rmux;
    end
    wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & st.ack;
    wm     = wmerge(rmux, wb_sel_i, wb_dat_i);

    // software writes win over counting
    if (wr_hit) begin
      case ({wb_adr_i[ADR_W-1:2], 2'b00})
        OFS_AUX_CTRL:  next_st.aux_c    = dtu_ctrl_t'(wm[$bits(dtu_ctrl_t)-1:0]);
        OFS_CORE_CTRL: next_st.core_c   = dtu_ctrl_t'(wm[$bits(dtu_ctrl_t)-1:0]);
        OFS_CAP_CTRL:  next_st.cap_c    = dtu_capctl_t'(wm[$bits(dtu_capctl_t)-1:0]);
        OFS_AUX_CNT:   next_st.aux_cnt  = wm[CNT_W-1:0];
        OFS_CORE_CNT:  next_st.core_cnt = wm[CNT_W-1:0];
        OFS_CAPTURE_RELOAD_REG:    next_st.capture_reload_reg   = wm[CNT_W-1:0];
        OFS_IRQ_CLR:   iclr             = wm[IRQ_W-1:0];
        OFS_IRQ_EN:    next_st.ien      = wm[IRQ_W-1:0];
        default:       next_st.ien      = st.ien;
      endcase
    end

    // capture wins over a software write
    if (cap_trig) begin
      next_st.capture_reload_reg = st.aux_cnt;
      if (st.cap_c.clear_en) begin
        next_st.aux_cnt = CNT_ZERO;
      end
    end

    // sticky status, set beats clear
    next_st.ists = (st.ists & ~iclr) | {cap_trig, core_wrap, aux_wrap};
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st        <= '0;
      st.aux_c  <= CTRL_RST;
      st.core_c <= CTRL_RST;
      st.cap_c  <= CAP_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign wb_dat_o       = st.rdat;
  assign wb_ack_o       = st.ack;
  assign toggle_out_pin = st.latch & st.core_c.out_en; // latch onto pin
  assign core_wrap_evt  = st.wrap_evt;
  assign irq            = |(st.ists & st.ien);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  latch_flip_a: assert property (core_wrap |=> st.latch != $past(st.latch))
    else $error("toggle latch did not flip on core wrap");
  latch_hold_a: assert property (!core_wrap |=> st.latch == $past(st.latch))
    else $error("toggle latch moved without core wrap");
  wrap_event_a: assert property (core_wrap |=> core_wrap_evt ##1
                                 (!core_wrap_evt || $past(core_wrap)))
    else $error("core wrap event missing or stretched");
  wrap_flag_a: assert property (core_wrap |=> st.ists[IRQ_CORE_WRAP])
    else $error("core wrap did not set its status bit");
  core_reload_a: assert property (core_wrap && st.core_c.reload_en && !wr_hit
                                  |=> st.core_cnt == $past(st.capture_reload_reg))
    else $error("core timer not reloaded from capture register");
  cap_copy_a: assert property (cap_trig |=> st.capture_reload_reg == $past(st.aux_cnt))
    else $error("capture register did not take aux count");
  cap_flag_a: assert property (cap_trig |=> st.ists[IRQ_CAPTURE])
    else $error("capture did not set its status bit");
  cap_keep_a: assert property (!cap_trig && !wr_hit |=> $stable(st.capture_reload_reg))
    else $error("capture register changed without capture or write");
  cap_clear_a: assert property (cap_trig && st.cap_c.clear_en |=> st.aux_cnt == CNT_ZERO)
    else $error("aux timer not cleared after capture");
  pre_gap_a: assert property (st.core_c.mode == MODE_TIMER && !core_step && !wr_hit
                              |=> $stable(st.core_cnt))
    else $error("core timer moved without prescaler tick");
  gate_stop_a: assert property (st.core_c.mode == MODE_GATED
                                && st.s2[P_COR_IN] != st.core_c.gate_high && !wr_hit
                                |=> $stable(st.core_cnt))
    else $error("core timer counted with gate closed");
  count_up_a: assert property (core_step && !st.core_c.dir_down && !st.core_c.ext_dir_en
                               && !core_wrap && !wr_hit
                               |=> st.core_cnt == CNT_W'($past(st.core_cnt) + 1))
    else $error("core timer did not count up by one");
  pin_edge_a: assert property (st.cap_c.src == CSRC_PIN && st.cap_c.edge_sel == EDGE_RISE
                               && $rose(st.s2[P_CAP]) |-> cap_trig)
    else $error("synchronised capture edge not detected");
  sync_pipe_a: assert property (st.s2 == $past(st.s1))
    else $error("pin synchroniser stage skipped");
  other_dir_a: assert property (st.cap_c.src == CSRC_ODIR
                                && $changed(st.s2[P_OTH_DR]) |-> cap_trig)
    else $error("other module direction edge did not capture");
  aux_stop_a: assert property (!aux_step && !cap_trig && !wr_hit
                               |=> $stable(st.aux_cnt))
    else $error("aux timer moved without a step");
  aux_up_a: assert property (aux_step && !st.aux_c.dir_down && !st.aux_c.ext_dir_en
                             && !cap_trig && !wr_hit
                             |=> st.aux_cnt == CNT_W'($past(st.aux_cnt) + 1))
    else $error("aux timer did not count up by one");
  aux_down_a: assert property (aux_step && st.aux_c.dir_down && !st.aux_c.ext_dir_en
                               && !cap_trig && !wr_hit
                               |=> st.aux_cnt == CNT_W'($past(st.aux_cnt) - 1))
    else $error("aux timer did not count down by one");
  aux_pin_dir_a: assert property (aux_step && !st.aux_c.dir_down && st.aux_c.ext_dir_en
                                  && st.s2[P_AUX_DR] && !cap_trig && !wr_hit
                                  |=> st.aux_cnt == CNT_W'($past(st.aux_cnt) - 1))
    else $error("direction pin did not turn aux timer down");
  aux_latch_a: assert property (st.aux_c.run && st.aux_c.mode == MODE_LATCH
                                |-> aux_step == core_wrap)
    else $error("aux timer not clocked by toggle latch");
  out_off_a: assert property (!st.core_c.out_en |-> !toggle_out_pin)
    else $error("toggle pin driven while output disabled");

endmodule

// ### testbench/dtu_pin_model.sv
// far-side pin driver: held levels plus counted toggle bursts
`timescale 1ns/1ps
module dtu_pin_model (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [6:0] lvl,
  input  wire logic [2:0] pidx,
  input  wire logic [7:0] pnum,
  input  wire logic       go,
  input  wire logic       slow,
  output logic            busy,
  output logic [6:0]      pins
);
  logic [8:0] left;
  logic [2:0] tmr;
  logic [6:0] tgl;

  // pins are the requested levels with burst toggles on top
  assign busy = (left != 9'h000);
  assign pins = lvl ^ tgl;

  // each level stands two or six cycles so the synchronisers see it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 9'h000;
      tmr  <= 3'h0;
      tgl  <= 7'h00;
    end else if (go && !busy) begin
      left <= {pnum, 1'b0};
      tmr  <= slow ? 3'h5 : 3'h1;
    end else if (busy) begin
      if (tmr == 3'h0) begin
        tgl[pidx] <= ~tgl[pidx];
        left      <= left - 9'h001;
        tmr       <= slow ? 3'h5 : 3'h1;
      end else begin
        tmr <= tmr - 3'h1;
      end
    end
  end
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the dual timer capture/reload unit
`timescale 1ns/1ps
module tb_top;
  import dtu_pkg::*;
  logic             mclk = 1'b0;
  logic             rst_b = 1'b0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [SEL_W-1:0] sel = '0;
  logic [SEL_W-1:0] wsel = 4'hF;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] dato;
  logic [DAT_W-1:0] rdat;
  logic             ack;
  logic [6:0]       lvl = 7'h00;
  logic [6:0]       pins;
  logic [2:0]       pidx = 3'h0;
  logic [7:0]       pnum = 8'h00;
  logic             go = 1'b0;
  logic             slow = 1'b0;
  logic             busy;
  logic             tog;
  logic             wrap_evt;
  logic             irq;
  logic             last_tog = 1'b0;
  int               fail_count = 0;
  int               compares = 0;
  int               wraps = 0;
  int               flips = 0;
  int               k;

  dtu_timer_unit uut (
    .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .aux_in_pin(pins[P_AUX_IN]), .core_in_pin(pins[P_COR_IN]),
    .aux_dir_pin(pins[P_AUX_DR]), .core_dir_pin(pins[P_COR_DR]),
    .capture_in_pin(pins[P_CAP]), .other_module_count_in(pins[P_OTH_CN]),
    .other_module_dir_in(pins[P_OTH_DR]), .toggle_out_pin(tog),
    .core_wrap_evt(wrap_evt), .irq(irq)
  );

  dtu_pin_model far (
    .mclk(mclk), .rst_b(rst_b), .lvl(lvl), .pidx(pidx), .pnum(pnum),
    .go(go), .slow(slow), .busy(busy), .pins(pins)
  );

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // count core wraps and toggle pin flips
  always @(posedge mclk) begin
    if (wrap_evt === 1'b1) begin
      wraps <= wraps + 1;
    end
    if (tog !== last_tog) begin
      flips <= flips + 1;
    end
    last_tog <= tog;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("counts: compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic bad(input string m);
    fail_count++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task automatic chk(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      bad($sformatf("got %h exp %h", got, exp));
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    int n;
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= wsel;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge mclk);
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      bad("bus timeout");
      results();
    end
  endtask

  task automatic rc(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
    wb(1'b0, a, '0);
    chk(rdat, e);
  endtask

  task automatic pulse(input int i, input int n);
    int j;
    @(posedge mclk);
    pidx <= 3'(i);
    pnum <= 8'(n);
    go   <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (j = 0; j < 3000 && busy !== 1'b0; j++) @(posedge mclk);
    if (j >= 3000) begin
      bad("pin timeout");
      results();
    end
    idle(5);
  endtask

  task automatic setpin(input int i, input logic v);
    @(posedge mclk);
    lvl[i] <= v;
    idle(6);
  endtask

  // run a timer for d cycles between two control writes
  task automatic tmeas(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] c, input int d);
    wb(1'b1, a, c | 32'h400);
    idle(d - 3);
    wb(1'b1, a, c);
  endtask

  task automatic wwrap(output int n);
    @(posedge mclk);
    for (n = 1; n < 200 && wrap_evt !== 1'b1; n++) @(posedge mclk);
    if (n >= 200) begin
      bad("wrap timeout");
      results();
    end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    idle(5);
    rst_b <= 1'b1;
    for (int a = 0; a <= 32; a += 4) begin
      rc(8'(a), '0);
    end
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    rc(8'h40, '0);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, OFS_AUX_CNT, '0);
      tmeas(OFS_AUX_CTRL, 32'(c), 2 * (4 << c));
      rc(OFS_AUX_CNT, 32'h2);
    end
    setpin(P_COR_IN, 1'b1);
    tmeas(OFS_CORE_CTRL, 32'h29, 16);
    rc(OFS_CORE_CNT, 32'h2);
    setpin(P_COR_IN, 1'b0);
    tmeas(OFS_CORE_CTRL, 32'h29, 16);
    rc(OFS_CORE_CNT, 32'h2);
    $display("test prescale done");
    wb(1'b1, OFS_AUX_CNT, '0);
    wb(1'b1, OFS_AUX_CTRL, 32'h450);
    pulse(P_AUX_IN, 5);
    rc(OFS_AUX_CNT, 32'h5);
    slow <= 1'b1;
    wb(1'b1, OFS_AUX_CTRL, 32'h550);
    pulse(P_AUX_IN, 3);
    rc(OFS_AUX_CNT, 32'h2);
    setpin(P_AUX_DR, 1'b1);
    wb(1'b1, OFS_AUX_CTRL, 32'h650);
    pulse(P_AUX_IN, 3);
    rc(OFS_AUX_CNT, 32'hFFFF);
    rc(OFS_IRQ_STAT, 32'h1);
    wb(1'b1, OFS_AUX_CTRL, 32'h4D0);
    pulse(P_AUX_IN, 2);
    rc(OFS_AUX_CNT, 32'h3);
    slow <= 1'b0;
    wb(1'b1, OFS_IRQ_EN, 32'h1);
    idle(1);
    chk(32'(irq), 32'h1);
    wb(1'b1, OFS_IRQ_CLR, 32'h1);
    rc(OFS_IRQ_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test counter done");
    wb(1'b1, OFS_AUX_CNT, '0);
    wb(1'b1, OFS_AUX_CTRL, 32'h418);
    wb(1'b1, OFS_CAPTURE_RELOAD_REG, 32'hFFFC);
    wb(1'b1, OFS_CORE_CNT, 32'hFFFE);
    wb(1'b1, OFS_CORE_CTRL, 32'h1C00);
    wwrap(k);
    wwrap(k);
    chk(32'(k), 32'h10);
    wb(1'b1, OFS_CORE_CTRL, 32'h1000);
    idle(4);
    chk(32'(flips), 32'(wraps));
    chk(32'(tog), 32'(wraps % 2));
    rc(OFS_AUX_CNT, 32'(wraps));
    chk(32'(wraps > 1), 32'h1);
    rc(OFS_IRQ_STAT, 32'h2);
    chk(32'(irq), 32'h0);
    $display("test wrap done");
    wb(1'b1, OFS_AUX_CNT, '0);
    wb(1'b1, OFS_AUX_CTRL, 32'h450);
    pulse(P_AUX_IN, 5);
    wb(1'b1, OFS_CAP_CTRL, 32'h5);
    setpin(P_CAP, 1'b1);
    rc(OFS_CAPTURE_RELOAD_REG, 32'h5);
    rc(OFS_AUX_CNT, 32'h0);
    pulse(P_AUX_IN, 2);
    setpin(P_CAP, 1'b0);
    rc(OFS_CAPTURE_RELOAD_REG, 32'h5);
    for (int s = 1; s < 4; s++) begin
      wb(1'b1, OFS_CAP_CTRL, 32'(s << 3));
      pulse(P_AUX_IN, s);
      k = (s == 1) ? P_OTH_CN : P_OTH_DR;
      setpin(k, ~lvl[k]);
      rc(OFS_CAPTURE_RELOAD_REG, 32'(2 + s * (s + 1) / 2));
    end
    wb(1'b1, OFS_CAP_CTRL, 32'h2);
    setpin(P_CAP, 1'b1);
    pulse(P_AUX_IN, 1);
    setpin(P_CAP, 1'b0);
    rc(OFS_CAPTURE_RELOAD_REG, 32'h9);
    wb(1'b1, OFS_IRQ_EN, 32'h4);
    idle(1);
    chk(32'(irq), 32'h1);
    rc(OFS_IRQ_CLR, 32'h0);
    wb(1'b1, OFS_IRQ_CLR, 32'h6);
    rc(OFS_IRQ_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    wsel = 4'h1;
    wb(1'b1, OFS_CAPTURE_RELOAD_REG, 32'h0000ABCD);
    wsel = 4'hF;
    rc(OFS_CAPTURE_RELOAD_REG, 32'hCD);
    $display("test capture done");
    results();
  end
endmodule
